//--- hdl/uart_control_autobaud_regs.v
// UART control, status and auto-baud sync logic behind an APB slave
// Behaviour
// - Bad sync bit time sets sync-inconsistent flag
// - LIN mode: non-0x55 sync sets inconsistent flag
// - Writing one clears flag, receiver returns idle
// - Break needs eleven bit times low
// - Break-seen set on sync; clears on data/write
// - Wait-for-break takes any-width break; reads zero
// - Enables 7,6,5 gate matching status flags
// - Start-frame detect interrupts on receive vector
// - Auto-baud error interrupts on receive vector
// - Loop-back feeds transmit into receive
// - Line driver field: off, external, internal
// - Receiver disable flushes and resets auto-baud
// - Transmitter disable waits until both empty
// - Start detect falling edge wakes system
// - Open drain drives low only
// - Double speed divides by eight, async only
// - Receiver mode field decodes four speeds
// - Generic auto-baud accepts any valid span
// - LIN sync: two bits 32 plus-minus 6
// - Multiprocessor filter drops non-address frames
// - Communication mode selects layout and protocol
// - Character size decodes five to nine bits
// - Parity field: off, even, odd
// - Stop-bit count affects transmitter only
//
// Added by the designer: the APB slave port.
`include "uart_control_autobaud_regs_defs.vh"
`default_nettype none

module uart_control_autobaud_regs #(
  parameter [7:0] SAMPLE_DIV = 8'h04,
  parameter [11:0] GEN_MIN_SPAN = 12'h040,
  parameter [11:0] GEN_MAX_SPAN = 12'hff0
) (
  input wire clk, // System clock
  input wire reset_n, // Synchronous reset
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  input wire rxdPin, // Receive pin
  input wire txBit, // Serial bit from transmitter
  input wire rxBufferNonEmpty, // Unread receive data held
  input wire txBufferFull, // Transmit buffer holds data
  input wire txShiftBusy, // Transmit shifter holds data
  input wire txFrameDone, // Pulse: frame shifted out, buffer empty
  input wire txcVectorAck, // Pulse: transmit complete vector taken
  input wire rxFrameDone, // Pulse: frame received
  input wire rxFrameAddress, // Received frame carries address bit
  output reg rxLine, // Receive line seen by the receiver
  output reg txdOut, // Transmit pin output value
  output reg txdOe, // Transmit pin output enable
  output reg transmitEnablePin, // External line driver enable
  output reg receiverActive, // Receiver owns the receive pin
  output reg transmitterActive, // Transmitter owns the transmit pin
  output reg rxFlush, // Pulse: flush buffer and error flags
  output reg rxReturnIdle, // Pulse: receiver back to idle
  output reg rxFrameAccept, // Pulse: frame passes filter
  output reg wakeRequest, // Pulse: wake from sleep
  output reg rxCompleteIrq, // Receive vector request
  output reg txCompleteIrq, // Transmit complete vector request
  output reg txEmptyIrq, // Data empty vector request
  output reg [4:0] samplesPerBit, // Baud divider divisor
  output reg [3:0] dataBits, // Data bits per frame
  output reg nineBitLowFirst, // Nine-bit low byte first
  output reg parityEnable, // Parity generated and checked
  output reg parityOdd, // Odd parity selected
  output reg twoStopBits, // Transmitter sends two stop bits
  output reg [1:0] commMode, // Communication mode
  output reg spiLsbFirst, // Master SPI data order
  output reg spiClockPhase, // Master SPI clock phase
  output reg syncValid, // Pulse: sync accepted
  output reg [11:0] syncSpan // Samples over eight sync bits
);

  localparam [3:0] AB_IDLE = 4'b0001;
  localparam [3:0] AB_BREAK = 4'b0010;
  localparam [3:0] AB_SYNC_START = 4'b0100;
  localparam [3:0] AB_SYNC = 4'b1000;

  localparam [11:0] BREAK_SAMPLES = `BREAK_BITS * {7'h00, `OVERSAMPLE_NORMAL};
  localparam [11:0] LIN_MIN = `LIN_TWO_BIT_NOMINAL - `LIN_TWO_BIT_TOLERANCE;
  localparam [11:0] LIN_MAX = `LIN_TWO_BIT_NOMINAL + `LIN_TWO_BIT_TOLERANCE;

  reg [7:0] lineControl;
  reg [7:0] enableControl;
  reg [7:0] formatControl;
  reg txCompleteFlag;
  reg startFrameFlag;
  reg syncInconsistent;
  reg breakSeen;
  reg waitBreak;
  reg [2:0] rxSync;
  reg prevRx;
  reg rxEnPrev;
  reg [7:0] divCount;
  reg sampleTick;
  reg [3:0] abState;
  reg [11:0] lowCount;
  reg [11:0] intervalCount;
  reg [11:0] totalCount;
  reg [2:0] edgeCount;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire [3:0] regIndex = paddr[5:2];
  wire inRange = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00);
  wire isStatus = inRange && (regIndex == `IDX_STATUS);
  wire isLine = inRange && (regIndex == `IDX_INTERRUPT_AND_LINE_CONTROL);
  wire isEnable = inRange && (regIndex == `IDX_ENABLE_AND_RECEIVE_MODE_CONTROL);
  wire isFormat = inRange && (regIndex == `IDX_FRAME_FORMAT_CONTROL);
  wire mapped = isStatus || isLine || isEnable || isFormat;
  wire setupPhase = psel && !penable;
  wire writeTaken = psel && penable && pready && pwrite && mapped;
  wire statusWrite = writeTaken && isStatus;

  // Writing zero to a clearable flag leaves it alone
  wire clrTxComplete = statusWrite && pwdata[`ST_TX_COMPLETE];
  wire clrStartFrame = statusWrite && pwdata[`ST_START_FRAME];
  wire clrSync = statusWrite && pwdata[`ST_SYNC_INCONSISTENT];
  wire clrBreak = statusWrite && pwdata[`ST_BREAK_SEEN];
  wire armWaitBreak = statusWrite && pwdata[`ST_WAIT_BREAK];

  ////////////////////////////////////////////////////////////////////////////
  // Field views

  wire receiver_enable = enableControl[`CB_RECEIVER_ENABLE];
  wire transmitter_enable = enableControl[`CB_TRANSMITTER_ENABLE];
  wire startDetect = enableControl[`CB_START_DETECT];
  wire openDrain = enableControl[`CB_OPEN_DRAIN];
  wire mpFilter = enableControl[`CB_MULTIPROCESSOR];
  wire [1:0] speedMode = enableControl[2:1];
  wire [1:0] lineDriver = lineControl[1:0];
  wire [1:0] modeSel = formatControl[7:6];
  wire isSpi = (modeSel == `COMM_MASTER_SPI);
  wire txBusy = txShiftBusy || txBufferFull;
  wire txEmpty = !txBufferFull;

  // Auto-baud only runs as asynchronous receiver
  wire autobaudOn = receiver_enable && speedMode[1] && (modeSel == `COMM_ASYNC);
  wire linMode = (speedMode == `SPEED_LIN_AUTO);
  wire fallEdge = prevRx && !rxLine;
  wire riseEdge = !prevRx && rxLine;

  wire [7:0] statusView = {rxBufferNonEmpty, txCompleteFlag, txEmpty,
                           startFrameFlag && startDetect, syncInconsistent, 1'b0,
                           breakSeen, 1'b0};
  wire [7:0] formatView = isSpi ? (formatControl & `CC_SPI_READ_MASK) : formatControl;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and control registers

  always @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      lineControl <= `RST_INTERRUPT_AND_LINE_CONTROL;
      enableControl <= `RST_ENABLE_AND_RECEIVE_MODE_CONTROL;
      formatControl <= `RST_FRAME_FORMAT_CONTROL;
    end else begin
      // Zero wait states: ready rises for the access phase only
      pready <= setupPhase;
      pslverr <= setupPhase && !mapped;
      if (setupPhase && !pwrite) begin
        if (isStatus) begin
          prdata <= {24'h000000, statusView};
        end else if (isLine) begin
          prdata <= {24'h000000, lineControl};
        end else if (isEnable) begin
          prdata <= {24'h000000, enableControl};
        end else if (isFormat) begin
          prdata <= {24'h000000, formatView};
        end else begin
          prdata <= 32'h00000000;
        end
      end
      if (writeTaken && isLine) begin
        lineControl <= pwdata[7:0];
      end
      if (writeTaken && isEnable) begin
        enableControl <= pwdata[7:0] & `CB_WRITE_MASK;
      end
      if (writeTaken && isFormat) begin
        formatControl <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive pin synchroniser, loop-back and sample divider

  always @(posedge clk) begin
    if (!reset_n) begin
      rxSync <= 3'b111;
      rxLine <= 1'b1;
      prevRx <= 1'b1;
      divCount <= 8'h00;
      sampleTick <= 1'b0;
    end else begin
      rxSync <= {rxSync[1:0], rxdPin};
      if (lineControl[`CA_LOOPBACK]) begin
        rxLine <= txBit;
      end else if (rxSync[1] == rxSync[2]) begin
        rxLine <= rxSync[2];
      end
      prevRx <= rxLine;
      sampleTick <= (divCount == SAMPLE_DIV - 8'h01);
      if (divCount == SAMPLE_DIV - 8'h01) begin
        divCount <= 8'h00;
      end else begin
        divCount <= divCount + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto-baud break and sync measurement

  // A short low pulse is no break, unless wait-for-break was armed
  wire breakLongEnough = (lowCount >= BREAK_SAMPLES) || waitBreak;
  wire linIntervalBad = linMode && ((intervalCount < LIN_MIN) ||
                        (intervalCount > LIN_MAX));
  wire [11:0] spanNow = totalCount + 12'h001;
  wire genSpanOk = (spanNow >= GEN_MIN_SPAN) && (spanNow <= GEN_MAX_SPAN);
  wire lastEdge = (edgeCount == `SYNC_LAST_INTERVAL);
  // In LIN mode missing edges show as a stretched interval, so a wrong sync value is caught
  wire syncTimeout = (linMode && (intervalCount > LIN_MAX)) ||
                     (totalCount > GEN_MAX_SPAN);
  wire inSync = (abState == AB_SYNC);
  wire syncBadNow = inSync && ((fallEdge && (linIntervalBad ||
                    (lastEdge && !genSpanOk))) || (!fallEdge && syncTimeout));
  wire syncGoodNow = inSync && fallEdge && lastEdge && !linIntervalBad &&
                     genSpanOk;

  always @(posedge clk) begin
    if (!reset_n) begin
      abState <= AB_IDLE;
      lowCount <= 12'h000;
      intervalCount <= 12'h000;
      totalCount <= 12'h000;
      edgeCount <= 3'h0;
      syncValid <= 1'b0;
      syncSpan <= 12'h000;
    end else begin
      syncValid <= syncGoodNow;
      if (syncGoodNow) begin
        syncSpan <= spanNow;
      end
      if (!autobaudOn || clrSync) begin
        abState <= AB_IDLE;
      end else begin
        case (abState)
          AB_IDLE: begin
            lowCount <= 12'h000;
            if (fallEdge) begin
              abState <= AB_BREAK;
            end
          end
          AB_BREAK: begin
            if (sampleTick && (lowCount != 12'hfff)) begin
              lowCount <= lowCount + 12'h001;
            end
            if (riseEdge) begin
              abState <= breakLongEnough ? AB_SYNC_START : AB_IDLE;
            end
          end
          AB_SYNC_START: begin
            intervalCount <= 12'h000;
            totalCount <= 12'h000;
            edgeCount <= 3'h0;
            if (fallEdge) begin
              abState <= AB_SYNC;
            end
          end
          AB_SYNC: begin
            if (syncBadNow || syncGoodNow) begin
              abState <= AB_IDLE;
            end else if (fallEdge) begin
              // The tick of the edge cycle belongs to the new interval
              edgeCount <= edgeCount + 3'h1;
              intervalCount <= {11'h000, sampleTick};
              totalCount <= totalCount + {11'h000, sampleTick};
            end else if (sampleTick) begin
              intervalCount <= intervalCount + 12'h001;
              totalCount <= totalCount + 12'h001;
            end
          end
          default: begin
            abState <= AB_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; in every flag a set beats a simultaneous clear

  wire breakTaken = (abState == AB_BREAK) && riseEdge && breakLongEnough;

  always @(posedge clk) begin
    if (!reset_n) begin
      txCompleteFlag <= 1'b0;
      startFrameFlag <= 1'b0;
      syncInconsistent <= 1'b0;
      breakSeen <= 1'b0;
      waitBreak <= 1'b0;
    end else begin
      txCompleteFlag <= txFrameDone || (txCompleteFlag && !clrTxComplete && !txcVectorAck);
      startFrameFlag <= (startDetect && receiver_enable && fallEdge) ||
                        (startFrameFlag && !clrStartFrame);
      syncInconsistent <= syncBadNow || (syncInconsistent && !clrSync);
      breakSeen <= syncGoodNow ||
                   (breakSeen && !clrBreak && !rxFrameDone);
      if (armWaitBreak) begin
        waitBreak <= 1'b1;
      end else if (breakTaken || !autobaudOn) begin
        waitBreak <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins, enables, interrupts and decoded configuration

  // Internal line-driver mode drives the pin only while a frame is pending
  wire pinDriven = transmitterActive &&
                   ((lineDriver != `LINE_DRIVER_INT) || txBusy);

  always @(posedge clk) begin
    if (!reset_n) begin
      txdOut <= 1'b1;
      txdOe <= 1'b0;
      transmitEnablePin <= 1'b0;
      receiverActive <= 1'b0;
      transmitterActive <= 1'b0;
      rxEnPrev <= 1'b0;
      rxFlush <= 1'b0;
      rxReturnIdle <= 1'b0;
      rxFrameAccept <= 1'b0;
      wakeRequest <= 1'b0;
      rxCompleteIrq <= 1'b0;
      txCompleteIrq <= 1'b0;
      txEmptyIrq <= 1'b0;
      samplesPerBit <= `OVERSAMPLE_NORMAL;
      dataBits <= 4'h8;
      nineBitLowFirst <= 1'b0;
      parityEnable <= 1'b0;
      parityOdd <= 1'b0;
      twoStopBits <= 1'b0;
      commMode <= `COMM_ASYNC;
      spiLsbFirst <= 1'b0;
      spiClockPhase <= 1'b0;
    end else begin
      receiverActive <= receiver_enable;
      rxEnPrev <= receiver_enable;
      rxFlush <= rxEnPrev && !receiver_enable;
      rxReturnIdle <= clrSync;
      // Pin is kept until shifter and buffer have drained
      transmitterActive <= transmitter_enable || (transmitterActive && txBusy);
      txdOut <= openDrain ? 1'b0 : txBit;
      txdOe <= pinDriven && (!openDrain || !txBit);
      transmitEnablePin <= (lineDriver == `LINE_DRIVER_EXT) &&
                           transmitterActive && txBusy;
      rxFrameAccept <= rxFrameDone && (!mpFilter || rxFrameAddress);
      wakeRequest <= startDetect && receiver_enable && fallEdge;
      rxCompleteIrq <= (lineControl[`CA_RX_COMPLETE_IE] && rxBufferNonEmpty) ||
                       (lineControl[`CA_START_FRAME_IE] && startDetect &&
                        startFrameFlag) ||
                       (lineControl[`CA_AUTOBAUD_ERR_IE] && syncInconsistent);
      txCompleteIrq <= lineControl[`CA_TX_COMPLETE_IE] && txCompleteFlag;
      txEmptyIrq <= lineControl[`CA_TX_EMPTY_IE] && txEmpty;
      // Double speed has no effect outside asynchronous operation
      samplesPerBit <= ((speedMode == `SPEED_DOUBLE) && (modeSel == `COMM_ASYNC)) ?
                       `OVERSAMPLE_DOUBLE : `OVERSAMPLE_NORMAL;
      commMode <= modeSel;
      spiLsbFirst <= isSpi && formatControl[2];
      spiClockPhase <= isSpi && formatControl[1];
      // Reserved sizes fall back to eight bits
      case (formatControl[2:0])
        3'h0: dataBits <= 4'h5;
        3'h1: dataBits <= 4'h6;
        3'h2: dataBits <= 4'h7;
        `CHARACTER_SIZE_NINE_LOW: dataBits <= 4'h9;
        `CHARACTER_SIZE_NINE_HIGH: dataBits <= 4'h9;
        default: dataBits <= 4'h8;
      endcase
      nineBitLowFirst <= !isSpi && (formatControl[2:0] == `CHARACTER_SIZE_NINE_LOW);
      parityEnable <= !isSpi && ((formatControl[5:4] == `PARITY_EVEN) ||
                      (formatControl[5:4] == `PARITY_ODD));
      parityOdd <= !isSpi && (formatControl[5:4] == `PARITY_ODD);
      twoStopBits <= !isSpi && formatControl[3];
    end
  end

endmodule

`default_nettype wire

//--- hdl/uart_control_autobaud_regs_defs.vh
// Register map, field positions, reset values and timing constants for the UART control block
`ifndef UART_CONTROL_AUTOBAUD_REGS_DEFS_VH
`define UART_CONTROL_AUTOBAUD_REGS_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_STATUS 4'h4
`define IDX_INTERRUPT_AND_LINE_CONTROL 4'h5
`define IDX_ENABLE_AND_RECEIVE_MODE_CONTROL 4'h6
`define IDX_FRAME_FORMAT_CONTROL 4'h7

// Reset values
`define RST_INTERRUPT_AND_LINE_CONTROL 8'h00
`define RST_ENABLE_AND_RECEIVE_MODE_CONTROL 8'h00
`define RST_FRAME_FORMAT_CONTROL 8'h03

// Status bit positions
`define ST_RX_COMPLETE 7
`define ST_TX_COMPLETE 6
`define ST_TX_EMPTY 5
`define ST_START_FRAME 4
`define ST_SYNC_INCONSISTENT 3
`define ST_BREAK_SEEN 1
`define ST_WAIT_BREAK 0

// Interrupt and line control fields
`define CA_RX_COMPLETE_IE 7
`define CA_TX_COMPLETE_IE 6
`define CA_TX_EMPTY_IE 5
`define CA_START_FRAME_IE 4
`define CA_LOOPBACK 3
`define CA_AUTOBAUD_ERR_IE 2
`define LINE_DRIVER_OFF 2'h0
`define LINE_DRIVER_EXT 2'h1
`define LINE_DRIVER_INT 2'h2

// Enable and receive mode fields
`define CB_RECEIVER_ENABLE 7
`define CB_TRANSMITTER_ENABLE 6
`define CB_START_DETECT 4
`define CB_OPEN_DRAIN 3
`define CB_MULTIPROCESSOR 0
`define CB_WRITE_MASK 8'hdf
`define SPEED_NORMAL 2'h0
`define SPEED_DOUBLE 2'h1
`define SPEED_GENERIC_AUTO 2'h2
`define SPEED_LIN_AUTO 2'h3

// Frame format fields
`define COMM_ASYNC 2'h0
`define COMM_SYNC 2'h1
`define COMM_INFRARED 2'h2
`define COMM_MASTER_SPI 2'h3
`define CC_SPI_READ_MASK 8'hc6
`define PARITY_EVEN 2'h2
`define PARITY_ODD 2'h3
`define CHARACTER_SIZE_NINE_LOW 3'h6
`define CHARACTER_SIZE_NINE_HIGH 3'h7

// Timing in baud samples
`define OVERSAMPLE_NORMAL 5'h10
`define OVERSAMPLE_DOUBLE 5'h08
`define BREAK_BITS 12'h00b
`define LIN_TWO_BIT_NOMINAL 12'h020
`define LIN_TWO_BIT_TOLERANCE 12'h006
`define SYNC_LAST_INTERVAL 3'h3

`endif

//--- tb/serial_node.sv
// Remote serial node driving the receive line
`default_nettype none
module serial_node (
  input wire logic clk, // Bench clock
  output var logic rxd // Line to the receive pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd = 1'b1;
  // LSB first, each bit held b clocks; last bit stays on the line
  task automatic send(input logic [15:0] v, input int n, input int b);
    for (int i = 0; i < n; i++) begin
      rxd <= v[i];
      repeat (b) @(posedge clk);
    end
  endtask
  // Break of k bits, two idle bits, sync character
  task automatic frame(input int k, input logic [7:0] d, input int b);
    send(16'h0, k, b);
    send(16'hffff, 2, b);
    send({7'h7f, d, 1'b0}, 13, b);
  endtask
endmodule
`default_nettype wire

//--- tb/uart_control_autobaud_regs_bench.sv
// Self-checking bench for the UART control and auto-baud block
`include "uart_control_autobaud_regs_defs.vh"
`default_nettype none
module uart_control_autobaud_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = 16;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdat;
  logic txBit = 1'b1, rxBufferNonEmpty = 1'b0, txBufferFull = 1'b0, txShiftBusy = 1'b0;
  logic txFrameDone = 1'b0, txcVectorAck = 1'b0, rxFrameDone = 1'b0, rxFrameAddress = 1'b0;
  logic rerr;
  wire [31:0] prdata;
  wire [11:0] syncSpan;
  wire [4:0] samplesPerBit;
  wire [3:0] dataBits;
  wire [1:0] commMode;
  wire pready, pslverr, rxdPin, rxLine, txdOut, txdOe, transmitEnablePin, receiverActive;
  wire transmitterActive, rxFlush, rxReturnIdle, rxFrameAccept, wakeRequest, syncValid;
  wire rxCompleteIrq, txCompleteIrq, txEmptyIrq, parityEnable, parityOdd, twoStopBits;
  wire nineBitLowFirst, spiLsbFirst, spiClockPhase;
  int errors = 0, checked = 0, nSync = 0, nIdle = 0, nFlush = 0, nWake = 0, nAcc = 0;
  uart_control_autobaud_regs #(.SAMPLE_DIV(8'h01)) uut (.*);
  serial_node node (.clk(clk), .rxd(rxdPin));
  always #25 clk = ~clk;
  // Pulses are counted so a scenario can judge them after they have passed
  always @(posedge clk) begin
    if (syncValid) nSync <= nSync + 1;
    if (rxReturnIdle) nIdle <= nIdle + 1;
    if (rxFlush) nFlush <= nFlush + 1;
    if (wakeRequest) nWake <= nWake + 1;
    if (rxFrameAccept) nAcc <= nAcc + 1;
  end
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    tick(3);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic frameDone(input logic adr);
    rxFrameAddress <= adr;
    rxFrameDone <= 1'b1;
    tick(1);
    rxFrameDone <= 1'b0;
    tick(2);
  endtask
  task automatic t_regs();
    logic [11:0] ra[4] = '{12'h014, 12'h018, 12'h01c, 12'h020};
    logic [31:0] re[4] = '{32'h0, 32'h0, 32'h3, 32'h0};
    for (int i = 0; i < 4; i++) begin
      rd(ra[i]);
      chk("reset value", re[i], rdat);
      chk("slave error", 32'(i == 3), 32'(rerr));
    end
    wr(12'h018, 32'hff);
    rd(12'h018);
    chk("enable bits", 32'hdf, rdat);
    wr(12'h018, 32'h0);
  endtask
  task automatic t_format();
    logic [3:0] sz[8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h8, 4'h8, 4'h9, 4'h9};
    logic [2:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      wr(12'h01c, {26'h0, v[1:0], v[0], v});
      chk("data bits", 32'(sz[i]), 32'(dataBits));
      chk("parity", {30'h0, v[1], &v[1:0]}, {30'h0, parityEnable, parityOdd});
      chk("stop bits", 32'(v[0]), 32'(twoStopBits));
      chk("nine low", 32'(i == 6), 32'(nineBitLowFirst));
    end
    wr(12'h01c, 32'hff);
    rd(12'h01c);
    chk("spi layout", 32'hc6, rdat);
    chk("comm mode", 32'h3, 32'(commMode));
    wr(12'h01c, 32'h03);
    wr(12'h018, 32'h02);
    chk("double div", 32'h8, 32'(samplesPerBit));
    wr(12'h01c, 32'h43);
    chk("sync div", 32'h10, 32'(samplesPerBit));
    wr(12'h01c, 32'h03);
    wr(12'h018, 32'h0);
  endtask
  task automatic t_irq();
    int w;
    wr(12'h014, 32'he0);
    chk("empty irq", 32'h1, 32'(txEmptyIrq));
    rxBufferNonEmpty <= 1'b1;
    txBufferFull <= 1'b1;
    txFrameDone <= 1'b1;
    tick(1);
    txFrameDone <= 1'b0;
    tick(2);
    chk("irqs set", 32'h6, {29'h0, rxCompleteIrq, txCompleteIrq, txEmptyIrq});
    rxBufferNonEmpty <= 1'b0;
    txBufferFull <= 1'b0;
    txcVectorAck <= 1'b1;
    tick(1);
    txcVectorAck <= 1'b0;
    tick(2);
    chk("irqs clear", 32'h1, {29'h0, rxCompleteIrq, txCompleteIrq, txEmptyIrq});
    wr(12'h014, 32'h10);
    wr(12'h018, 32'h90);
    w = nWake;
    node.send(16'h2, 2, 8);
    chk("wake", w + 1, nWake);
    chk("start irq", 32'h1, 32'(rxCompleteIrq));
    wr(12'h010, 32'h10);
    chk("start irq off", 32'h0, 32'(rxCompleteIrq));
  endtask
  task automatic t_pins();
    wr(12'h014, 32'h09);
    txBit <= 1'b0;
    txShiftBusy <= 1'b1;
    wr(12'h018, 32'h48);
    chk("loop low", 32'h0, 32'(rxLine));
    chk("drive low", 32'h2, {30'h0, txdOe, txdOut});
    chk("ext driver", 32'h1, 32'(transmitEnablePin));
    txBit <= 1'b1;
    tick(3);
    chk("float high", 32'h0, 32'(txdOe));
    chk("loop high", 32'h1, 32'(rxLine));
    wr(12'h018, 32'h0);
    chk("tx drains", 32'h1, 32'(transmitterActive));
    txShiftBusy <= 1'b0;
    tick(3);
    chk("tx released", 32'h0, {30'h0, transmitterActive, txdOe});
    wr(12'h014, 32'h04);
  endtask
  task automatic t_autobaud();
    int s;
    int q;
    s = nSync;
    wr(12'h018, 32'h84);
    node.frame(12, 8'h55, 24);
    chk("generic sync", s + 1, nSync);
    chk("generic span", 8 * 24, 32'(syncSpan));
    wr(12'h018, 32'h86);
    node.frame(12, 8'h55, BIT);
    chk("lin sync", s + 2, nSync);
    chk("lin span", 8 * BIT, 32'(syncSpan));
    rd(12'h010);
    chk("break seen", 32'h2, rdat & 32'h2);
    frameDone(1'b0);
    rd(12'h010);
    chk("break gone", 32'h0, rdat & 32'h2);
    node.frame(12, 8'h55, 24);
    rd(12'h010);
    chk("slow sync", 32'h8, rdat & 32'h8);
    chk("error irq", 32'h1, 32'(rxCompleteIrq));
    wr(12'h010, 32'h0);
    rd(12'h010);
    chk("flag kept", 32'h8, rdat & 32'h8);
    q = nIdle;
    wr(12'h010, 32'h08);
    rd(12'h010);
    chk("flag cleared", 32'h0, rdat & 32'h8);
    chk("rx idle", q + 1, nIdle);
    node.frame(12, 8'h35, BIT);
    rd(12'h010);
    chk("bad value", 32'h8, rdat & 32'h8);
    wr(12'h010, 32'h08);
    node.frame(8, 8'h55, BIT);
    chk("short break", s + 2, nSync);
    wr(12'h010, 32'h09);
    rd(12'h010);
    chk("arm reads 0", 32'h0, rdat & 32'h1);
    node.frame(8, 8'h55, BIT);
    chk("any break", s + 3, nSync);
  endtask
  task automatic t_rx();
    int a;
    int f;
    wr(12'h018, 32'h81);
    a = nAcc;
    frameDone(1'b0);
    chk("data dropped", a, nAcc);
    frameDone(1'b1);
    chk("address kept", a + 1, nAcc);
    f = nFlush;
    wr(12'h018, 32'h0);
    chk("rx flush", f + 1, nFlush);
  endtask
  task automatic end_of_test();
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    tick(5);
    reset_n <= 1'b1;
    chk("reset div", 32'h10, 32'(samplesPerBit));
    t_regs();
    t_format();
    t_irq();
    t_pins();
    t_autobaud();
    t_rx();
    end_of_test();
  end
  initial begin
    tick(40000);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire

//--- tb/uart_control_autobaud_regs_properties.sv
// Port-level assertions for the UART control block
`default_nettype none
module uart_control_autobaud_regs_properties #(
  parameter [11:0] GEN_MIN_SPAN = 12'h040,
  parameter [11:0] GEN_MAX_SPAN = 12'hff0
) (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic rxFrameDone, // Frame in
  input wire logic rxFrameAccept, // Frame kept
  input wire logic rxFlush, // Flush
  input wire logic receiverActive, // Rx on
  input wire logic transmitterActive, // Tx on
  input wire logic txShiftBusy, // Shifter
  input wire logic txBufferFull, // Buffer
  input wire logic txdOe, // Pin enable
  input wire logic [4:0] samplesPerBit, // Divisor
  input wire logic [3:0] dataBits, // Size
  input wire logic parityEnable, // Parity
  input wire logic parityOdd, // Odd
  input wire logic syncValid, // Sync
  input wire logic [11:0] syncSpan // Span
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence setupCycle;
    psel && !penable;
  endsequence
  sequence accessOnce;
    psel && penable && pready ##1 !pready;
  endsequence
  a_apb_answer: assert property (setupCycle |=> accessOnce)
    else $error("late APB answer");
  a_error_ready: assert property (pslverr |-> pready)
    else $error("slave error outside access");
  a_filter_cause: assert property (rxFrameAccept |-> $past(rxFrameDone))
    else $error("accept without frame");
  a_flush_off: assert property (rxFlush |-> !receiverActive)
    else $error("flush while receiver on");
  a_tx_drain: assert property ((txShiftBusy || txBufferFull) && transmitterActive |=> transmitterActive)
    else $error("tx dropped early");
  a_pin_release: assert property (!transmitterActive && !$past(transmitterActive) |-> !txdOe)
    else $error("pin driven with transmitter off");
  a_divisor_value: assert property (samplesPerBit == 5'h10 || samplesPerBit == 5'h08)
    else $error("bad divisor");
  a_size_range: assert property (dataBits >= 4'h5 && dataBits <= 4'h9)
    else $error("bad data size");
  a_parity_odd: assert property (parityOdd |-> parityEnable)
    else $error("odd parity while parity off");
  a_sync_span: assert property (syncValid |-> syncSpan >= GEN_MIN_SPAN && syncSpan <= GEN_MAX_SPAN)
    else $error("sync accepted out of range");
  a_sync_pulse: assert property (syncValid |=> !syncValid)
    else $error("sync pulse too long");
endmodule
bind uart_control_autobaud_regs uart_control_autobaud_regs_properties #(
  .GEN_MIN_SPAN(GEN_MIN_SPAN), .GEN_MAX_SPAN(GEN_MAX_SPAN)
) props (.*);
`default_nettype wire
